// File: src/pis_irq_status.sv
/*
  Interrupt status and event control register of the transceiver:
  seven sticky clear-on-read event flags, eight enables, interrupt
  gating and the shared power-down / interrupt pin.
  Assumes event strobes and control bits are synchronous to clk_sys,
  and that the interrupt control register lives elsewhere and
  arrives here as level inputs.
*/
// How it works
// RULE1: A flag sets when its event happened since the last status read.
// RULE2: Flags record events whether or not their enable is set.
// RULE3: An enabled pending event raises the interrupt.
// RULE4: No event interrupt unless the global control permits it.
// RULE5: Bit 15 is link quality, resets 0, read-only, cleared by read.
// RULE6: Bit 14 is energy detect, resets 0, read-only, cleared by read.
// RULE7: Bit 13 is link status change, resets 0, cleared by read.
// RULE8: Bit 12 is speed change, or speed/duplex change when map select set.
// RULE9: Bit 11 is duplex change, or precision-time event when map select set.
// RULE10: Precision-time flag re-arms only after its status register empties.
// RULE11: Software reads precision-time details from its own status register.
// RULE12: Bit 10 is auto-negotiation complete, resets 0, cleared by read.
// RULE13: Counter mode zero: bit 9 is false carrier counter half-full.
// RULE14: Counter mode nonzero: bit 9 is false carrier or receive error half-full.
// RULE15: Bits 7:0 are read-write enables, bit 7 for link quality, in order.
// RULE16: Global interrupt enable gates all event interrupts.
// RULE17: Test interrupt bit keeps the interrupt asserted while set.
// RULE18: Output enable makes the power-down pin an interrupt output.
// RULE19: An event in the clearing read cycle stays pending.
`timescale 1ns/1ps
module pis_irq_status (
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // Management register access
  input  wire logic [4:0]             reg_addr,
  input  wire logic                   reg_rd_en,
  input  wire logic                   reg_wr_en,
  input  wire logic [15:0]            reg_wdata,
  output logic [15:0]                 reg_rdata,
  // Interrupt control bits
  input  wire logic                   interrupt_map_select,
  input  wire logic                   global_irq_enable,
  input  wire logic                   test_irq_force,
  input  wire logic                   irq_output_enable,
  input  wire logic [1:0]             counter_mode_sel,
  // Event strobes
  input  wire logic                   ev_link_quality,
  input  wire logic                   ev_energy_detect,
  input  wire logic                   ev_link_change,
  input  wire logic                   ev_speed_change,
  input  wire logic                   ev_duplex_change,
  input  wire logic                   ev_precision_time,
  input  wire logic                   ev_autoneg_done,
  input  wire logic                   ev_false_carrier_half,
  input  wire logic                   ev_rx_error_half,
  input  wire logic                   precision_time_status_empty,
  // Shared power-down / interrupt pin, active low interrupt
  input  wire logic                   powerdown_irq_pin_in,
  output logic                        powerdown_irq_pin_out,
  output logic                        powerdown_irq_pin_oe,
  output logic                        powerdown_req,
  output logic                        irq_active
);

  // ==========================================================
  // Address decode
  function automatic logic status_hit(input logic [4:0] addr);
    if (addr == pis_pkg::ADDR_STATUS_EVENT) begin
      status_hit = 1'h1;
    end else begin
      status_hit = 1'h0;
    end
  endfunction

  logic                          rd_hit;
  logic                          wr_hit;
  logic [pis_pkg::NUM_FLAGS-1:0] flags;
  logic [pis_pkg::NUM_FLAGS-1:0] evt_vec;
  logic [pis_pkg::EN_W-1:0]      enable_r;
  logic                          irq_nxt;
  logic                          ptp_evt;

  assign rd_hit = reg_rd_en && status_hit(reg_addr);
  assign wr_hit = reg_wr_en && status_hit(reg_addr);

  // ==========================================================
  // Precision-time re-arm
  pis_pkg::pis_ptp_state_t ptp_state_r;

  // Event only counts while armed; held until the status queue drains
  assign ptp_evt = ev_precision_time && (ptp_state_r == pis_pkg::PIS_PTP_ARMED); // RULE10

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ptp_state_r <= pis_pkg::PIS_PTP_ARMED;
    end else begin
      case (ptp_state_r)
        pis_pkg::PIS_PTP_ARMED: begin
          if (ptp_evt && interrupt_map_select && !precision_time_status_empty) begin // RULE10
            ptp_state_r <= pis_pkg::PIS_PTP_HELD;
          end
        end
        pis_pkg::PIS_PTP_HELD: begin
          if (precision_time_status_empty) begin // RULE10
            ptp_state_r <= pis_pkg::PIS_PTP_ARMED;
          end
        end
        default: begin
          ptp_state_r <= pis_pkg::PIS_PTP_ARMED;
        end
      endcase
    end
  end

  // ==========================================================
  // Event selection per flag
  always_comb begin
    evt_vec = '0;
    evt_vec[pis_pkg::IDX_LINK_QUAL] = ev_link_quality; // RULE5
    evt_vec[pis_pkg::IDX_ENERGY]    = ev_energy_detect; // RULE6
    evt_vec[pis_pkg::IDX_LINK]      = ev_link_change; // RULE7
    evt_vec[pis_pkg::IDX_AUTONEG]   = ev_autoneg_done; // RULE12
    if (interrupt_map_select) begin
      evt_vec[pis_pkg::IDX_SPEED]   = ev_speed_change || ev_duplex_change; // RULE8
      evt_vec[pis_pkg::IDX_DUP_PTP] = ptp_evt; // RULE9
    end else begin
      evt_vec[pis_pkg::IDX_SPEED]   = ev_speed_change; // RULE8
      evt_vec[pis_pkg::IDX_DUP_PTP] = ev_duplex_change; // RULE9
    end
    if (counter_mode_sel == pis_pkg::CTR_MODE_PLAIN) begin
      evt_vec[pis_pkg::IDX_COUNTER] = ev_false_carrier_half; // RULE13
    end else begin
      evt_vec[pis_pkg::IDX_COUNTER] = ev_false_carrier_half || ev_rx_error_half; // RULE14
    end
  end

  // ==========================================================
  // Sticky flags, recorded regardless of enables
  genvar gi;
  generate
    for (gi = 0; gi < pis_pkg::NUM_FLAGS; gi++) begin : g_flag
      pis_flag_cell pis_flag_cell_inst (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .set_pulse   (evt_vec[gi]), // RULE2
        .clear_pulse (rd_hit),
        .flag_q      (flags[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Enables and read data
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_r <= pis_pkg::ENABLE_RST;
    end else if (wr_hit) begin
      enable_r <= reg_wdata[pis_pkg::EN_W-1:0]; // RULE15
    end
  end

  // Other management addresses belong to other blocks and read zero here
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= pis_pkg::RDATA_RST;
    end else if (rd_hit) begin
      reg_rdata <= {flags, 1'h0, enable_r}; // RULE5
    end else if (reg_rd_en) begin
      reg_rdata <= pis_pkg::RDATA_RST;
    end
  end

  // ==========================================================
  // Interrupt generation and pin
  assign irq_nxt = ((|(flags & enable_r[pis_pkg::EN_W-1:pis_pkg::EN_FLAG_LSB]))
                    && global_irq_enable) // RULE3 RULE4 RULE16
                   || test_irq_force; // RULE17

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_active            <= 1'h0;
      powerdown_irq_pin_oe  <= 1'h0;
      powerdown_irq_pin_out <= 1'h1;
      powerdown_req         <= 1'h0;
    end else begin
      irq_active            <= irq_nxt;
      // Open-drain style: drive low only while signalling
      powerdown_irq_pin_oe  <= irq_output_enable && irq_nxt; // RULE18
      powerdown_irq_pin_out <= 1'h0;
      powerdown_req         <= !irq_output_enable && !powerdown_irq_pin_in; // RULE18
    end
  end

  // ==========================================================
  // Checks
  sequence s_quiet;
    (!global_irq_enable && !test_irq_force) [*2];
  endsequence

  sequence s_write;
    wr_hit ##1 1'b1;
  endsequence

  property p_flag_set;
    @(posedge clk_sys) disable iff (!reset_n)
      (evt_vec != '0) |=> ((flags & $past(evt_vec)) == $past(evt_vec));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("event not recorded"); // RULE1

  property p_record_disabled;
    @(posedge clk_sys) disable iff (!reset_n)
      (ev_link_quality && !enable_r[7]) |=> flags[pis_pkg::IDX_LINK_QUAL];
  endproperty
  a_record_disabled: assert property (p_record_disabled) else $error("event lost"); // RULE2

  property p_irq_enabled;
    @(posedge clk_sys) disable iff (!reset_n)
      (flags[pis_pkg::IDX_LINK] && enable_r[5] && global_irq_enable) |=> irq_active;
  endproperty
  a_irq_enabled: assert property (p_irq_enabled) else $error("enabled event no irq"); // RULE3

  property p_irq_gated;
    @(posedge clk_sys) disable iff (!reset_n)
      s_quiet |=> !irq_active;
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq without global enable"); // RULE4

  property p_read_clears;
    @(posedge clk_sys) disable iff (!reset_n)
      (rd_hit && evt_vec == '0) |=> (flags == '0) && (reg_rdata[15:9] == $past(flags));
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // RULE5

  property p_speed_dup_map;
    @(posedge clk_sys) disable iff (!reset_n)
      (interrupt_map_select && ev_duplex_change) |=> flags[pis_pkg::IDX_SPEED];
  endproperty
  a_speed_dup_map: assert property (p_speed_dup_map) else $error("duplex not on bit 12"); // RULE8

  property p_ptp_hold;
    @(posedge clk_sys) disable iff (!reset_n)
      (ptp_state_r == pis_pkg::PIS_PTP_HELD && !precision_time_status_empty)
        |=> ptp_state_r == pis_pkg::PIS_PTP_HELD;
  endproperty
  a_ptp_hold: assert property (p_ptp_hold) else $error("ptp re-armed early"); // RULE10

  property p_ctr_mode;
    @(posedge clk_sys) disable iff (!reset_n)
      (counter_mode_sel != 2'h0 && ev_rx_error_half) |=> flags[pis_pkg::IDX_COUNTER];
  endproperty
  a_ctr_mode: assert property (p_ctr_mode) else $error("rx error half-full lost"); // RULE14

  property p_enable_write;
    @(posedge clk_sys) disable iff (!reset_n)
      s_write |-> enable_r == $past(reg_wdata[7:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost"); // RULE15

  property p_test_irq;
    @(posedge clk_sys) disable iff (!reset_n)
      test_irq_force [*2] |-> ##1 irq_active;
  endproperty
  a_test_irq: assert property (p_test_irq) else $error("test irq not held"); // RULE17

  property p_pin_input;
    @(posedge clk_sys) disable iff (!reset_n)
      !irq_output_enable |=> !powerdown_irq_pin_oe;
  endproperty
  a_pin_input: assert property (p_pin_input) else $error("pin driven as input"); // RULE18

endmodule

// File: src/pis_pkg.sv
/*
  Constants for the interrupt status and event control block of the
  transceiver: register offset, field positions, reset values.
  Assumes a 5-bit management register address and 16-bit data.
*/
package pis_pkg;

  // ==========================================================
  // Register map
  localparam logic [4:0]  ADDR_STATUS_EVENT = 5'h12;
  localparam int          REG_W             = 16;
  localparam int          ADDR_W            = 5;

  // ==========================================================
  // Field layout: flags 15..9, bit 8 reads zero, enables 7..0
  localparam int          NUM_FLAGS  = 7;
  localparam int          FLAG_LSB   = 9;
  localparam int          FLAG_MSB   = 15;
  localparam int          RSVD_BIT   = 8;
  localparam int          EN_W       = 8;
  localparam int          EN_FLAG_LSB = 1;

  // Flag index within the flag vector (status bit = FLAG_LSB + index)
  localparam int          IDX_COUNTER   = 0;
  localparam int          IDX_AUTONEG   = 1;
  localparam int          IDX_DUP_PTP   = 2;
  localparam int          IDX_SPEED     = 3;
  localparam int          IDX_LINK      = 4;
  localparam int          IDX_ENERGY    = 5;
  localparam int          IDX_LINK_QUAL = 6;

  // ==========================================================
  // Reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RST  = 7'h00;
  localparam logic [EN_W-1:0]      ENABLE_RST = 8'h00;
  localparam logic [REG_W-1:0]     RDATA_RST  = 16'h0000;
  localparam logic [1:0]           CTR_MODE_PLAIN = 2'h0;

  // ==========================================================
  // Precision-time re-arm state, Gray coded
  typedef enum logic [0:0] {
    PIS_PTP_ARMED = 1'h0,
    PIS_PTP_HELD  = 1'h1
  } pis_ptp_state_t;

endpackage

// File: src/pis_flag_cell.sv
/*
  One sticky event flag, cleared by a status read.
  Assumes set and clear are single-cycle strobes on clk_sys.
*/
`timescale 1ns/1ps
module pis_flag_cell (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag_q
);

  // An event in the clearing cycle survives the read
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'h0;
    end else if (set_pulse) begin // RULE1 RULE19
      flag_q <= 1'h1;
    end else if (clear_pulse) begin
      flag_q <= 1'h0;
    end
  end

endmodule

// File: dv/pis_irq_status_test.sv
/*
  Self-checking testbench for the interrupt status and event control block.
  Drives every input directly at the falling clock edge.
  Assumes one-cycle register strobes and event pulses, all on clk_sys.
*/
`timescale 1ns/1ps
module pis_irq_status_test;
  // ==========================================================
  // Stimulus and observation
  logic        clk_sys    = 1'b0;
  logic        reset_n    = 1'b0;
  logic [4:0]  addr       = 5'h00;
  logic        rd_en      = 1'b0;
  logic        wr_en      = 1'b0;
  logic [15:0] wdata      = 16'h0000;
  logic [15:0] rdata;
  logic        map_sel    = 1'b0;
  logic        glb_en     = 1'b0;
  logic        tforce     = 1'b0;
  logic        out_en     = 1'b0;
  logic [1:0]  cmode      = 2'h0;
  logic [8:0]  ev         = 9'h000;
  logic        ts_empty   = 1'b0;
  logic        pin_in     = 1'b1;
  logic        pin_out;
  logic        pin_oe;
  logic        pd_req;
  logic        irq;
  int          err_total  = 0;
  int          n_compared = 0;
  // Event bit feeding each flag index 0..6
  int          evmap [7]  = '{0, 2, 4, 5, 6, 7, 8};
  localparam logic [4:0] A = pis_pkg::ADDR_STATUS_EVENT;

  pis_irq_status pis_irq_status_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(addr), .reg_rd_en(rd_en),
    .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rdata(rdata),
    .interrupt_map_select(map_sel), .global_irq_enable(glb_en),
    .test_irq_force(tforce), .irq_output_enable(out_en), .counter_mode_sel(cmode),
    .ev_link_quality(ev[8]), .ev_energy_detect(ev[7]), .ev_link_change(ev[6]),
    .ev_speed_change(ev[5]), .ev_duplex_change(ev[4]), .ev_precision_time(ev[3]),
    .ev_autoneg_done(ev[2]), .ev_false_carrier_half(ev[0]), .ev_rx_error_half(ev[1]),
    .precision_time_status_empty(ts_empty), .powerdown_irq_pin_in(pin_in),
    .powerdown_irq_pin_out(pin_out), .powerdown_irq_pin_oe(pin_oe),
    .powerdown_req(pd_req), .irq_active(irq)
  );

  always #12.5 clk_sys = ~clk_sys;

  // ==========================================================
  // Access tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // Trailing idle cycle keeps back-to-back calls from re-driving a strobe
  task automatic wr(input logic [15:0] d);
    addr = A;
    wdata = d;
    wr_en = 1'b1;
    cyc(1);
    wr_en = 1'b0;
    cyc(1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    addr = a;
    rd_en = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    cyc(1);
    chk(rdata, exp);
  endtask

  task automatic pulse(input int b);
    ev[b] = 1'b1;
    cyc(1);
    ev = 9'h000;
    cyc(1);
  endtask

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    cyc(3);
    reset_n = 1'b1;
    cyc(1);
    rd(A, 16'h0000);
    chk({12'h000, pin_out, pin_oe, pd_req, irq}, 16'h0000);
    wr(16'hffff);
    rd(A, 16'h00ff);
    rd(5'h13, 16'h0000);
    wr(16'h0000);
    // All enables clear: flags still record, no interrupt
    glb_en = 1'b1;
    for (int i = 0; i < 7; i++) begin
      pulse(evmap[i]);
    end
    chk({15'h0000, irq}, 16'h0000);
    rd(A, 16'hfe00);
    rd(A, 16'h0000);
    // Only the matching enable may raise the interrupt
    for (int i = 0; i < 7; i++) begin
      wr({8'h00, 8'hfe & ~(8'h02 << i)});
      pulse(evmap[i]);
      cyc(1);
      chk({15'h0000, irq}, 16'h0000);
      wr({8'h00, 8'h02 << i});
      cyc(1);
      chk({15'h0000, irq}, 16'h0001);
      rd(A, 16'h0202 << i);
      cyc(1);
      chk({15'h0000, irq}, 16'h0000);
    end
    glb_en = 1'b0;
    wr(16'h0020);
    pulse(6);
    cyc(2);
    chk({15'h0000, irq}, 16'h0000);
    glb_en = 1'b1;
    cyc(2);
    chk({14'h0000, pin_oe, irq}, 16'h0001);
    out_en = 1'b1;
    cyc(2);
    chk({14'h0000, pin_oe, pin_out}, 16'h0002);
    rd(A, 16'h2020);
    cyc(1);
    chk({14'h0000, pin_oe, irq}, 16'h0000);
    glb_en = 1'b0;
    tforce = 1'b1;
    cyc(2);
    chk({14'h0000, pin_oe, irq}, 16'h0003);
    cyc(4);
    chk({14'h0000, pin_oe, irq}, 16'h0003);
    tforce = 1'b0;
    cyc(2);
    chk({15'h0000, irq}, 16'h0000);
    out_en = 1'b0;
    pin_in = 1'b0;
    cyc(2);
    chk({14'h0000, pin_oe, pd_req}, 16'h0001);
    out_en = 1'b1;
    cyc(2);
    chk({15'h0000, pd_req}, 16'h0000);
    pin_in = 1'b1;
    out_en = 1'b0;
    wr(16'h0000);
    // Event in the same cycle as the clearing read
    pulse(6);
    addr = A;
    rd_en = 1'b1;
    ev[6] = 1'b1;
    cyc(1);
    rd_en = 1'b0;
    ev = 9'h000;
    cyc(1);
    chk(rdata, 16'h2000);
    rd(A, 16'h2000);
    rd(A, 16'h0000);
    map_sel = 1'b1;
    pulse(4);
    rd(A, 16'h1000);
    pulse(5);
    rd(A, 16'h1000);
    pulse(3);
    rd(A, 16'h0800);
    pulse(3);
    rd(A, 16'h0000);
    ts_empty = 1'b1;
    cyc(2);
    ts_empty = 1'b0;
    pulse(3);
    rd(A, 16'h0800);
    map_sel = 1'b0;
    pulse(3);
    rd(A, 16'h0000);
    pulse(4);
    rd(A, 16'h0800);
    pulse(1);
    rd(A, 16'h0000);
    for (int m = 1; m < 4; m++) begin
      cmode = m[1:0];
      pulse(1);
      rd(A, 16'h0200);
      pulse(0);
      rd(A, 16'h0200);
    end
    finish_test();
  end
endmodule
